// ===== pkg/umaf_pkg.sv
// Package: register map, field layout and constants of the address-filtering UART
package umaf_pkg;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_DATA     = 8'h00;
  localparam logic [7:0] ADDR_CSA      = 8'h04;
  localparam logic [7:0] ADDR_CSB      = 8'h08;
  localparam logic [7:0] ADDR_SHARED   = 8'h0c;
  localparam logic [7:0] ADDR_BAUD_LO  = 8'h10;

  // ----------------------------------------------------------------
  // Control/status A fields
  // ----------------------------------------------------------------
  localparam int CSA_RX_DONE  = 7;
  localparam int CSA_TX_DONE  = 6;
  localparam int CSA_TX_EMPTY = 5;
  localparam int CSA_SPEED2X  = 1;
  localparam int CSA_FILTER   = 0;

  // Control B fields
  localparam int CSB_RX_EN    = 4;
  localparam int CSB_TX_EN    = 3;
  localparam int CSB_SIZE2    = 2;
  localparam int CSB_RX_NINTH = 1;
  localparam int CSB_TX_NINTH = 0;

  // Shared location: bit 7 picks the target
  localparam int SH_SELECT    = 7;
  localparam int FMT_STOP2    = 3;
  localparam int FMT_SIZE_LO  = 1;

  // ----------------------------------------------------------------
  // Reset values, sampling constants and the nine-bit size code
  // ----------------------------------------------------------------
  localparam logic [7:0] FMT_RESET  = 8'h06;
  localparam logic [4:0] SPB_NORMAL = 5'h10;
  localparam logic [4:0] SPB_DOUBLE = 5'h08;
  localparam logic [4:0] SF_NORMAL  = 5'h08;
  localparam logic [4:0] SF_DOUBLE  = 5'h04;
  localparam logic [4:0] SM_NORMAL  = 5'h09;
  localparam logic [4:0] SM_DOUBLE  = 5'h05;
  localparam logic [2:0] SIZE_NINE  = 3'h7;

  typedef enum logic [1:0] {
    UMAF_HTRANS_IDLE = 2'h0,
    UMAF_HTRANS_BUSY = 2'h1,
    UMAF_HTRANS_NSEQ = 2'h2,
    UMAF_HTRANS_SEQ  = 2'h3
  } umaf_htrans_t;

endpackage

// ===== design/umaf_top.sv
// Design: UART with multi-drop address filter behind an AHB-Lite slave
//
// Added by the designer: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ns

// Operation
// - Sample 16 times per bit normally, 8 times with speed doubling.
// - First vote sample is number 8 normally, 4 when doubled.
// - Middle vote sample is number 9 normally, 5 when doubled.
// - Bit value is majority of the three centre samples.
// - Data plus parity bits counted per frame span 5 to 10; the code has no parity bit and counts 5 to 9 data bits.
// - Stay synchronised within slow and fast ratio limits from sampling.
// - With filter on, frames without address mark are discarded.
// - Transmitter ignores the address filter enable.
// - For 5 to 8 bit characters the first stop bit marks type.
// - For nine-bit characters the ninth bit marks frame type.
// - Type indicator one is address frame, zero is data frame.
// - Address frame with filter on is buffered and sets done flag.
// - Transmitter and receiver share one character size setting.
// - Writing one to transmit-done clears it; zero leaves it.
// - Bit 7 of a shared-location write selects the target register.
// - Select zero writes the divisor's high four bits; one writes format.
module umaf_top #(
  parameter int BAUD_W = 12
) (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Serial line
  input  wire logic        rxd,
  output logic             txd
);

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  logic       wr_ph_q;
  logic       rd_ph_q;
  logic [7:0] addr_q;
  logic       ap_valid;

  assign ap_valid  = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ph_q <= 1'b0;
      rd_ph_q <= 1'b0;
      addr_q  <= 8'h00;
    end else begin
      wr_ph_q <= ap_valid && hwrite;
      rd_ph_q <= ap_valid && !hwrite;
      if (ap_valid) begin
        addr_q <= haddr[7:0];
      end
    end
  end

  logic [7:0] wd;
  logic       wr_data;
  logic       wr_csa;
  logic       wr_csb;
  logic       wr_sh;
  logic       wr_blo;
  logic       rd_data;

  assign wd      = hwdata[7:0];
  assign wr_data = wr_ph_q && (addr_q == umaf_pkg::ADDR_DATA);
  assign wr_csa  = wr_ph_q && (addr_q == umaf_pkg::ADDR_CSA);
  assign wr_csb  = wr_ph_q && (addr_q == umaf_pkg::ADDR_CSB);
  assign wr_sh   = wr_ph_q && (addr_q == umaf_pkg::ADDR_SHARED);
  assign wr_blo  = wr_ph_q && (addr_q == umaf_pkg::ADDR_BAUD_LO);
  assign rd_data = ap_valid && !hwrite
                   && (haddr[7:0] == umaf_pkg::ADDR_DATA);

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  logic             speed2x_q;
  logic             filter_en_q;
  logic             rx_en_q;
  logic             tx_en_q;
  logic             size2_q;
  logic             tx_ninth_q;
  logic [7:0]       fmt_q;
  logic [3:0]       baud_hi_q;
  logic [7:0]       baud_lo_q;
  logic [2:0]       char_size_code;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      speed2x_q   <= 1'b0;
      filter_en_q <= 1'b0;
    end else if (wr_csa) begin
      speed2x_q   <= wd[umaf_pkg::CSA_SPEED2X];
      filter_en_q <= wd[umaf_pkg::CSA_FILTER];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_en_q    <= 1'b0;
      tx_en_q    <= 1'b0;
      size2_q    <= 1'b0;
      tx_ninth_q <= 1'b0;
    end else if (wr_csb) begin
      rx_en_q    <= wd[umaf_pkg::CSB_RX_EN];
      tx_en_q    <= wd[umaf_pkg::CSB_TX_EN];
      size2_q    <= wd[umaf_pkg::CSB_SIZE2];
      tx_ninth_q <= wd[umaf_pkg::CSB_TX_NINTH];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fmt_q     <= umaf_pkg::FMT_RESET;
      baud_hi_q <= 4'h0;
      baud_lo_q <= 8'h00;
    end else begin
      if (wr_sh && wd[umaf_pkg::SH_SELECT]) begin
        fmt_q <= wd;
      end
      if (wr_sh && !wd[umaf_pkg::SH_SELECT]) begin
        baud_hi_q <= wd[3:0];
      end
      if (wr_blo) begin
        baud_lo_q <= wd;
      end
    end
  end

  // One size code for both directions
  assign char_size_code = {size2_q, fmt_q[umaf_pkg::FMT_SIZE_LO +: 2]};

  logic       nine;
  logic [3:0] nbits;
  assign nine  = (char_size_code == umaf_pkg::SIZE_NINE);
  assign nbits = nine ? 4'd9 : 4'(char_size_code[1:0]) + 4'd5;

  // ----------------------------------------------------------------
  // Sample tick from the divisor
  // ----------------------------------------------------------------
  logic [BAUD_W-1:0] bcnt_q;
  logic              tick;
  assign tick = (bcnt_q == '0);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bcnt_q <= '0;
    end else if (tick) begin
      bcnt_q <= BAUD_W'({baud_hi_q, baud_lo_q});
    end else begin
      bcnt_q <= bcnt_q - BAUD_W'(1);
    end
  end

  logic [4:0] spb;
  logic [4:0] s_first;
  logic [4:0] s_mid;
  assign spb     = speed2x_q ? umaf_pkg::SPB_DOUBLE : umaf_pkg::SPB_NORMAL;
  assign s_first = speed2x_q ? umaf_pkg::SF_DOUBLE : umaf_pkg::SF_NORMAL;
  assign s_mid   = speed2x_q ? umaf_pkg::SM_DOUBLE : umaf_pkg::SM_NORMAL;

  // ----------------------------------------------------------------
  // Receiver
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS, RX_STOP} umaf_rx_t;
  umaf_rx_t   rx_st_q;
  logic [4:0] smp_q;
  logic [3:0] ridx_q;
  logic [8:0] rsh_q;
  logic [1:0] votes_q;
  logic       vote;
  logic       bit_end;
  logic [7:0] rbuf_q;
  logic       rbuf9_q;
  logic       rx_done_q;

  // Majority of samples first, middle and last
  assign vote    = (votes_q[0] & votes_q[1]) | (rxd & (votes_q[0] | votes_q[1]));
  assign bit_end = tick && (smp_q == s_mid + 5'd1);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      votes_q <= 2'b00;
    end else if (tick && smp_q == s_first) begin
      votes_q[0] <= rxd;
    end else if (tick && smp_q == s_mid) begin
      votes_q[1] <= rxd;
    end
  end

  logic frame_type;
  logic keep;
  // Address mark: ninth bit or first stop bit
  assign frame_type = nine ? rsh_q[8] : vote;
  assign keep = !filter_en_q || frame_type;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_st_q <= RX_IDLE;
      smp_q   <= 5'd0;
      ridx_q  <= 4'd0;
      rsh_q   <= 9'h000;
    end else if (!rx_en_q) begin
      rx_st_q <= RX_IDLE;
    end else if (tick) begin
      smp_q <= (smp_q == spb) ? 5'd1 : smp_q + 5'd1;
      case (rx_st_q)
        RX_IDLE: begin
          if (!rxd) begin
            rx_st_q <= RX_START;
            smp_q   <= 5'd2;
          end
        end
        RX_START: begin
          if (bit_end) begin
            rx_st_q <= vote ? RX_IDLE : RX_BITS;
            ridx_q  <= 4'd0;
          end
        end
        RX_BITS: begin
          if (bit_end) begin
            // Data plus ninth bit, 5 to 9 bits, LSB first
            rsh_q  <= {vote, rsh_q[8:1]};
            ridx_q <= ridx_q + 4'd1;
            if (ridx_q == nbits - 4'd1) begin
              rx_st_q <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (bit_end) begin
            rx_st_q <= RX_IDLE;
          end
        end
        default: rx_st_q <= RX_IDLE;
      endcase
    end
  end

  logic       store;
  logic [8:0] aligned;
  assign store   = tick && bit_end && rx_st_q == RX_STOP && keep;
  assign aligned = rsh_q >> (4'd9 - nbits);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rbuf_q    <= 8'h00;
      rbuf9_q   <= 1'b0;
      rx_done_q <= 1'b0;
    end else begin
      if (store) begin
        // Filtered frames never reach here, nor touch the flag
        rbuf_q    <= aligned[7:0];
        rbuf9_q   <= nine & aligned[8];
        rx_done_q <= 1'b1;
      end else if (rd_data) begin
        rx_done_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Transmitter, blind to the filter enable
  // ----------------------------------------------------------------
  logic [11:0] tsh_q;
  logic [3:0]  tleft_q;
  logic [4:0]  tsmp_q;
  logic        tx_empty_q;
  logic [8:0]  tx_hold_q;
  logic        tx_done_q;
  logic        tx_busy;
  logic [3:0]  tlen;
  logic [11:0] tframe;

  assign tx_busy = (tleft_q != 4'd0);
  assign tlen    = nbits + 4'd2 + 4'(fmt_q[umaf_pkg::FMT_STOP2]);
  assign tframe  = ({3'b111, tx_hold_q} << 1) | (12'hfff << (nbits + 4'd1));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tsh_q      <= 12'hfff;
      tleft_q    <= 4'd0;
      tsmp_q     <= 5'd1;
      tx_empty_q <= 1'b1;
      tx_hold_q  <= 9'h000;
    end else begin
      if (wr_data && tx_empty_q) begin
        tx_hold_q  <= {tx_ninth_q, wd};
        tx_empty_q <= 1'b0;
      end else if (!tx_busy && !tx_empty_q && tx_en_q && tick) begin
        // Start on a tick, else the start bit is short by up to the divisor value in clocks
        tsh_q      <= tframe;
        tleft_q    <= tlen;
        tsmp_q     <= 5'd1;
        tx_empty_q <= 1'b1;
      end
      // Separate so a data write never swallows a shift tick
      if (tx_busy && tick) begin
        tsmp_q <= (tsmp_q == spb) ? 5'd1 : tsmp_q + 5'd1;
        if (tsmp_q == spb) begin
          tsh_q   <= {1'b1, tsh_q[11:1]};
          tleft_q <= tleft_q - 4'd1;
        end
      end
    end
  end

  assign txd = tsh_q[0];

  logic tx_fin;
  assign tx_fin = tx_busy && tick && tsmp_q == spb && tleft_q == 4'd1
                  && tx_empty_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_done_q <= 1'b0;
    end else if (tx_fin) begin
      tx_done_q <= 1'b1;
    end else if (wr_csa && wd[umaf_pkg::CSA_TX_DONE]) begin
      tx_done_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (ap_valid && !hwrite) begin
      case (haddr[7:0])
        umaf_pkg::ADDR_DATA:    hrdata <= {24'h0, rbuf_q};
        umaf_pkg::ADDR_CSA:     hrdata <= {24'h0, rx_done_q, tx_done_q,
                                  tx_empty_q, 3'b000, speed2x_q, filter_en_q};
        umaf_pkg::ADDR_CSB:     hrdata <= {24'h0, 3'b000, rx_en_q, tx_en_q,
                                  size2_q, rbuf9_q, tx_ninth_q};
        umaf_pkg::ADDR_SHARED:  hrdata <= {28'h0, baud_hi_q};
        umaf_pkg::ADDR_BAUD_LO: hrdata <= {24'h0, baud_lo_q};
        default:                hrdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule

// ===== sim/umaf_peer.sv
// Serial peer model: frames onto the receive line, samples the send line
`timescale 1ns/1ns
module umaf_peer (
  // Clock
  input  wire logic hclk,
  // Serial lines
  output logic      rxd,
  input  wire logic txd
);
  initial rxd = 1'b1;

  // --------------------------------
  // Frame sender
  // --------------------------------
  // Start, nd data bits, type bit, stop, then one idle bit
  task automatic send(input int nd, input logic [7:0] d, input logic tb,
                      input int len, input logic gl);
    logic [11:0] f;
    logic        g;
    int          i;
    int          k;
    f = 12'hfff;
    f[0] = 1'b0;
    for (i = 0; i < nd; i++) f[i + 1] = d[i];
    f[nd + 1] = tb;
    f[nd + 2] = 1'b1;
    for (i = 0; i < nd + 4; i++) begin
      for (k = 0; k < len; k++) begin
        // Spike one sample wide mid-bit; only the vote can hide it
        g = gl && i > 0 && i <= nd && k >= len / 2 && k < len / 2 + 2;
        @(posedge hclk);
        rxd <= f[i] ^ g;
      end
    end
  endtask

  // Waits for a start bit, then samples nb bits at their centres
  task automatic recv(input int nb, input int len, output logic [8:0] d);
    int i;
    d = 9'h0;
    i = 0;
    while (txd !== 1'b0 && i < 5000) begin
      @(posedge hclk);
      i++;
    end
    repeat (len / 2) @(posedge hclk);
    for (i = 0; i < nb; i++) begin
      repeat (len) @(posedge hclk);
      d[i] = txd;
    end
  endtask
endmodule

// ===== sim/umaf_chk.sv
// Checker: bus and serial-line properties at the top ports
`timescale 1ns/1ns
module umaf_chk #(
  parameter int BAUD_W = 12
) (
  // Clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // Bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // Serial
  input wire logic        rxd,
  input wire logic        txd
);
  logic              ap_q;
  logic              wr_q;
  logic [7:0]        ad_q;
  logic [BAUD_W-1:0] div_q;
  logic [1:0]        csa_q;
  logic              txd_q;
  int                cnt;
  int                bitlen;
  wire rd_dp = ap_q && !wr_q;
  wire wr_dp = ap_q && wr_q;
  wire mapped = ad_q inside {umaf_pkg::ADDR_DATA, umaf_pkg::ADDR_CSA,
    umaf_pkg::ADDR_CSB, umaf_pkg::ADDR_SHARED, umaf_pkg::ADDR_BAUD_LO};
  assign bitlen = (int'(div_q) + 1) * (csa_q[1] ? 8 : 16);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_q <= 1'b0;
      wr_q <= 1'b0;
      ad_q <= 8'h00;
    end else if (hready) begin
      ap_q <= hsel && htrans[1];
      wr_q <= hwrite;
      ad_q <= haddr[7:0];
    end
  end

  // Shadow of the settings that the properties depend on
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_q <= '0;
      csa_q <= 2'h0;
    end else if (wr_dp) begin
      if (ad_q == umaf_pkg::ADDR_BAUD_LO) div_q[7:0] <= hwdata[7:0];
      if (ad_q == umaf_pkg::ADDR_SHARED && !hwdata[7])
        div_q[BAUD_W-1:8] <= hwdata[BAUD_W-9:0];
      if (ad_q == umaf_pkg::ADDR_CSA) csa_q <= hwdata[1:0];
    end
  end

  // Length of the current run of one level on the send line
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      txd_q <= 1'b1;
      cnt   <= 0;
    end else begin
      txd_q <= txd;
      cnt   <= (txd != txd_q) ? 1 : cnt + 1;
    end
  end

  // --------------------------------
  // Properties
  // --------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_ready; hreadyout; endproperty
  a_ready: assert property (p_ready) else $error("wait state inserted");
  property p_okay; !hresp; endproperty
  a_okay: assert property (p_okay) else $error("error response");
  property p_unmapped; rd_dp && !mapped |-> hrdata == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read");
  property p_shared;
    rd_dp && ad_q == umaf_pkg::ADDR_SHARED |-> hrdata[3:0] == div_q[11:8];
  endproperty
  a_shared: assert property (p_shared) else $error("divisor high");
  property p_w1c;
    wr_dp && ad_q == umaf_pkg::ADDR_CSA && hwdata[6] ##2
    rd_dp && ad_q == umaf_pkg::ADDR_CSA |-> !hrdata[6];
  endproperty
  a_w1c: assert property (p_w1c) else $error("done flag kept");
  property p_ctrl;
    rd_dp && ad_q == umaf_pkg::ADDR_CSA |-> hrdata[1:0] == csa_q;
  endproperty
  a_ctrl: assert property (p_ctrl) else $error("control bits lost");
  property p_txbit; $rose(txd) |-> cnt >= bitlen && cnt % bitlen == 0;
  endproperty
  a_txbit: assert property (p_txbit) else $error("bit length");
  property p_hold;
    !(hsel && htrans[1] && !hwrite && hready) |=> $stable(hrdata);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved");

  c_shared: cover property (rd_dp && ad_q == umaf_pkg::ADDR_SHARED);
  c_w1c: cover property (wr_dp && ad_q == umaf_pkg::ADDR_CSA && hwdata[6]);
  c_tx: cover property ($rose(txd));
endmodule

// ===== sim/uart_multidrop_address_filter_tb_top.sv
// Testbench top: bus master, serial peer and result checks
`timescale 1ns/1ns
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin \
  n_mismatch++; \
  $display("wrong value at %0t: got %h expected %h", $time, (g), (e)); \
  end end
module uart_multidrop_address_filter_tb_top;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic        rxd, txd, dp_rd, last9;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize, code;
  logic [31:0] exp_q[$], msk_q[$];
  logic [7:0]  last_d, tx_d;
  logic [8:0]  got;
  int          n_mismatch, check_count, cycles, seed, nb;
  assign hready = hreadyout;

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  umaf_top #(.BAUD_W(12)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .rxd(rxd), .txd(txd));
  umaf_peer peer (.hclk(hclk), .rxd(rxd), .txd(txd));

  // --------------------------------
  // Bus master and read watcher
  // --------------------------------
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d, input logic [31:0] m, input logic [31:0] e);
    hsel   <= 1'b1;
    htrans <= umaf_pkg::UMAF_HTRANS_NSEQ;
    haddr  <= {24'h0, a};
    hwrite <= w;
    if (!w) begin
      exp_q.push_back(e);
      msk_q.push_back(m);
    end
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel   <= 1'b0;
    htrans <= umaf_pkg::UMAF_HTRANS_IDLE;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 32'h0, 32'h0);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, e);
    xfer(1'b0, a, 32'h0, m, e);
  endtask

  always @(posedge hclk) begin
    if (dp_rd && hready && msk_q.size() > 0) begin
      `CHK(hrdata & msk_q[0], exp_q[0] & msk_q[0])
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
    end
    dp_rd <= hsel && htrans[1] && !hwrite && hready;
  end

  // A discarded frame must leave flag, ninth bit and buffer as they were
  task automatic rx_case(input int nd, input logic tb, input int ln,
                         input logic acc, input logic nine);
    logic [7:0] d;
    d = 8'($random(seed));
    peer.send(nd, d, tb, ln, 1'b1);
    rd(umaf_pkg::ADDR_CSA, 32'h80, {24'h0, acc, 7'h0});
    if (acc) begin
      last_d = d & 8'((9'h1 << nd) - 9'h1);
      last9  = tb;
    end
    if (nine) rd(umaf_pkg::ADDR_CSB, 32'h2, {30'h0, last9, 1'b0});
    rd(umaf_pkg::ADDR_DATA, 32'hff, {24'h0, last_d});
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  always @(posedge hclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      close_out();
    end
  end

  // --------------------------------
  // Main sequence
  // --------------------------------
  initial begin
    seed = 32'h9d147120;
    {hsel, hwrite, last9} = 3'h0;
    {haddr, hwdata} = 64'h0;
    htrans = umaf_pkg::UMAF_HTRANS_IDLE;
    hsize = 3'h2;
    last_d = 8'h00;
    hresetn = 1'b0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    wr(umaf_pkg::ADDR_BAUD_LO, 32'h01);
    wr(umaf_pkg::ADDR_SHARED, 32'h05);
    rd(umaf_pkg::ADDR_SHARED, 32'hf, 32'h5);
    wr(umaf_pkg::ADDR_SHARED, 32'h86);
    rd(umaf_pkg::ADDR_SHARED, 32'hf, 32'h5);
    wr(umaf_pkg::ADDR_SHARED, 32'h00);
    // Divisor 0x501 was loaded meanwhile; let that count run out
    repeat (1300) @(posedge hclk);
    $display("test shared location done");
    for (nb = 5; nb <= 9; nb++) begin
      code = (nb == 9) ? umaf_pkg::SIZE_NINE : 3'(nb - 5);
      wr(umaf_pkg::ADDR_CSB, {27'h0, 2'h3, code[2], 2'h0});
      wr(umaf_pkg::ADDR_SHARED, {24'h0, 5'h10, code[1:0], 1'b0});
      rx_case(nb > 8 ? 8 : nb, 1'b1, 31 + nb % 3, 1'b1, nb == 9);
    end
    $display("test sizes and rates done");
    wr(umaf_pkg::ADDR_CSA, 32'h01);
    rx_case(8, 1'b0, 32, 1'b0, 1'b1);
    rx_case(8, 1'b1, 32, 1'b1, 1'b1);
    wr(umaf_pkg::ADDR_CSA, 32'h00);
    rx_case(8, 1'b0, 32, 1'b1, 1'b1);
    wr(umaf_pkg::ADDR_CSA, 32'h01);
    rx_case(8, 1'b0, 32, 1'b0, 1'b1);
    wr(umaf_pkg::ADDR_CSB, 32'h18);
    wr(umaf_pkg::ADDR_SHARED, 32'h8e);
    rx_case(8, 1'b0, 32, 1'b0, 1'b0);
    rx_case(8, 1'b1, 32, 1'b1, 1'b0);
    $display("test address filter done");
    wr(umaf_pkg::ADDR_CSA, 32'h02);
    rx_case(8, 1'b1, 16, 1'b1, 1'b0);
    $display("test double speed done");
    wr(umaf_pkg::ADDR_CSA, 32'h01);
    wr(umaf_pkg::ADDR_CSB, 32'h1d);
    wr(umaf_pkg::ADDR_SHARED, 32'h86);
    tx_d = 8'($random(seed));
    wr(umaf_pkg::ADDR_DATA, {24'h0, tx_d});
    peer.recv(9, 32, got);
    `CHK(got, {1'b1, tx_d})
    // Rest of the frame is under two bit times at this divisor
    repeat (64) @(posedge hclk);
    rd(umaf_pkg::ADDR_CSA, 32'h40, 32'h40);
    wr(umaf_pkg::ADDR_CSA, 32'h01);
    rd(umaf_pkg::ADDR_CSA, 32'h40, 32'h40);
    wr(umaf_pkg::ADDR_CSA, 32'h41);
    rd(umaf_pkg::ADDR_CSA, 32'h40, 32'h00);
    $display("test transmit done");
    wr(8'h14, 32'hff);
    rd(8'h14, 32'hffffffff, 32'h0);
    $display("test unmapped done");
    repeat (4) @(posedge hclk);
    close_out();
  end
endmodule

bind umaf_top umaf_chk #(.BAUD_W(BAUD_W)) u_chk (.hclk(hclk),
  .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .rxd(rxd),
  .txd(txd));
